// ===== sfcmd_core.sv
// serial flash command decoder: latch control, status read/write, single and dual reads
// assumes pins asynchronous to clk, array data valid one clk after arrayAddr, sclk at most clk/8
`timescale 1ns/1ps
`default_nettype none
module sfcmd_core #(
	parameter int unsigned STATUS_WRITE_TIME_NS = 10000000
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic clkEn,
	input wire logic chipSelectN,
	input wire logic serialClk,
	input wire logic lane0In,
	output logic lane0Out,
	output logic lane0Oe,
	input wire logic lane1In,
	output logic lane1Out,
	output logic lane1Oe,
	input wire logic writeProtectN,
	input wire logic arrayBusy,
	input wire logic arrayOpDone,
	output logic [23:0] arrayAddr,
	input wire logic [7:0] arrayData,
	output logic [7:0] statusByte
);
	localparam int unsigned STATUS_WRITE_CYCLES = STATUS_WRITE_TIME_NS / sfcmd_pkg::CLK_PERIOD_NS;

	logic [sfcmd_pkg::PIN_W-1:0] pinLvl;
	logic [sfcmd_pkg::PIN_W-1:0] pinRise;
	logic [sfcmd_pkg::PIN_W-1:0] pinFall;
	sfcmd_pkg::sfcmd_state_e state_q;
	sfcmd_pkg::sfcmd_state_e opcState;
	logic [4:0] cnt_q;
	logic [31:0] sh_q;
	logic [31:0] shNext;
	logic [7:0] opc_q;
	logic [7:0] opcNext;
	logic dual_q;
	logic dualAddr_q;
	logic [23:0] addr_q;
	logic [2:0] pos_q;
	logic [7:0] byte_q;
	logic [7:0] cur;
	logic [7:0] sr_q;
	logic [7:0] newSr_q;
	logic wel_q;
	logic volArm_q;
	logic wsrVol_q;
	logic run_q;
	logic nvBusy_q;
	logic [sfcmd_pkg::TIMER_W-1:0] timer_q;
	logic csLow;
	logic csRise;
	logic sclkRise;
	logic sclkFall;
	logic busy;
	logic addrDone;
	logic outState;
	logic byteEnd;
	logic cmd1Exec;
	logic wsrGo;
	logic timerDone;
	logic locked;

	function automatic logic [31:0] shiftIn(input logic [31:0] sh, input logic dual, input logic b1, input logic b0);
		shiftIn = dual ? {sh[29:0], b1, b0} : {sh[30:0], b0};
	endfunction

	sfcmd_sync i_sfcmd_sync (
		.clk(clk),
		.resetn(resetn),
		.clkEn(clkEn),
		.pinIn({writeProtectN, lane1In, lane0In, serialClk, chipSelectN}),
		.pinLvl(pinLvl),
		.pinRise(pinRise),
		.pinFall(pinFall)
	);

	assign csLow = !pinLvl[sfcmd_pkg::PIN_CS] && !pinRise[sfcmd_pkg::PIN_CS];
	assign csRise = pinRise[sfcmd_pkg::PIN_CS];
	assign sclkRise = csLow && pinRise[sfcmd_pkg::PIN_SCLK];
	assign sclkFall = csLow && pinFall[sfcmd_pkg::PIN_SCLK];
	assign busy = nvBusy_q || arrayBusy;
	assign locked = sr_q[sfcmd_pkg::SR_LOCK] && !pinLvl[sfcmd_pkg::PIN_WP];
	assign shNext = shiftIn(sh_q, dualAddr_q && state_q == sfcmd_pkg::ST_ADDR,
		pinLvl[sfcmd_pkg::PIN_LANE1], pinLvl[sfcmd_pkg::PIN_LANE0]);
	assign opcNext = {sh_q[6:0], pinLvl[sfcmd_pkg::PIN_LANE0]};
	assign addrDone = sclkRise && state_q == sfcmd_pkg::ST_ADDR &&
		cnt_q == (dualAddr_q ? sfcmd_pkg::CNT_DADDR_LAST : sfcmd_pkg::CNT_ADDR_LAST);
	assign outState = state_q == sfcmd_pkg::ST_SROUT || state_q == sfcmd_pkg::ST_RDOUT;
	assign byteEnd = sclkFall && outState && pos_q == (dual_q ? 3'h1 : 3'h0);
	assign cmd1Exec = csRise && state_q == sfcmd_pkg::ST_CMD1;
	assign wsrGo = csRise && state_q == sfcmd_pkg::ST_WRSR && cnt_q == sfcmd_pkg::CNT_WRSR_BYTE &&
		(wel_q || wsrVol_q) && !locked;
	assign timerDone = run_q && timer_q == sfcmd_pkg::TIMER_W'(1);
	assign statusByte = (sr_q & sfcmd_pkg::SR_WR_MASK) | {6'h00, wel_q, busy};
	assign arrayAddr = addr_q;
	assign cur = (pos_q == 3'h7) ? (state_q == sfcmd_pkg::ST_SROUT ? statusByte : arrayData) : byte_q;

	// opcode decode; busy lets only status read through
	always_comb begin
		opcState = sfcmd_pkg::ST_IGN;
		if (busy && opcNext != sfcmd_pkg::OPC_SR_READ) begin
			opcState = sfcmd_pkg::ST_IGN;
		end else begin
			case (opcNext)
				sfcmd_pkg::OPC_WEL_SET, sfcmd_pkg::OPC_WEL_CLR, sfcmd_pkg::OPC_VOL_ARM: opcState = sfcmd_pkg::ST_CMD1;
				sfcmd_pkg::OPC_SR_READ: opcState = sfcmd_pkg::ST_SROUT;
				sfcmd_pkg::OPC_SR_WRITE: opcState = sfcmd_pkg::ST_WRSR;
				sfcmd_pkg::OPC_READ, sfcmd_pkg::OPC_FAST_READ, sfcmd_pkg::OPC_DUAL_OUT,
				sfcmd_pkg::OPC_DUAL_IO: opcState = sfcmd_pkg::ST_ADDR;
				default: opcState = sfcmd_pkg::ST_IGN;
			endcase
		end
	end

	// input shifting and frame sequencing
	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_q <= sfcmd_pkg::ST_OPC;
			cnt_q <= 5'h00;
			sh_q <= 32'h00000000;
			opc_q <= 8'h00;
			dual_q <= 1'b0;
			dualAddr_q <= 1'b0;
		end else if (clkEn) begin
			if (!csLow) begin
				state_q <= sfcmd_pkg::ST_OPC;
				cnt_q <= 5'h00;
			end else if (sclkRise) begin
				sh_q <= shNext;
				case (state_q)
					sfcmd_pkg::ST_OPC: begin
						if (cnt_q == sfcmd_pkg::CNT_OPC_LAST) begin
							opc_q <= opcNext;
							state_q <= opcState;
							cnt_q <= 5'h00;
							dual_q <= opcNext == sfcmd_pkg::OPC_DUAL_OUT || opcNext == sfcmd_pkg::OPC_DUAL_IO;
							dualAddr_q <= opcNext == sfcmd_pkg::OPC_DUAL_IO;
						end else begin
							cnt_q <= cnt_q + 5'h01;
						end
					end
					sfcmd_pkg::ST_CMD1: state_q <= sfcmd_pkg::ST_IGN;
					sfcmd_pkg::ST_ADDR: begin
						cnt_q <= addrDone ? 5'h00 : cnt_q + 5'h01;
						if (addrDone) begin
							if (opc_q == sfcmd_pkg::OPC_READ || opc_q == sfcmd_pkg::OPC_DUAL_IO) begin
								state_q <= sfcmd_pkg::ST_RDOUT;
							end else begin
								state_q <= sfcmd_pkg::ST_DUMMY;
							end
						end
					end
					sfcmd_pkg::ST_DUMMY: begin
						cnt_q <= cnt_q + 5'h01;
						if (cnt_q == sfcmd_pkg::CNT_DUMMY_LAST) begin
							state_q <= sfcmd_pkg::ST_RDOUT;
						end
					end
					sfcmd_pkg::ST_WRSR: begin
						if (cnt_q != sfcmd_pkg::CNT_MAX) begin
							cnt_q <= cnt_q + 5'h01;
						end
					end
					default: state_q <= state_q;
				endcase
			end
		end
	end

	// read address: load after address phase, step after each byte
	always_ff @(posedge clk) begin
		if (!resetn) begin
			addr_q <= 24'h000000;
		end else if (clkEn) begin
			if (addrDone) begin
				addr_q <= dualAddr_q ? shNext[31:8] : shNext[23:0];
			end else if (byteEnd && state_q == sfcmd_pkg::ST_RDOUT) begin
				addr_q <= addr_q + 24'h000001;
			end
		end
	end

	// output shifting on falling edges
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pos_q <= 3'h7;
			byte_q <= 8'h00;
			lane0Out <= 1'b0;
			lane0Oe <= 1'b0;
			lane1Out <= 1'b0;
			lane1Oe <= 1'b0;
		end else if (clkEn) begin
			if (!csLow) begin
				pos_q <= 3'h7;
				lane0Oe <= 1'b0;
				lane1Oe <= 1'b0;
			end else if (sclkFall && outState) begin
				byte_q <= cur;
				lane1Out <= cur[pos_q];
				lane1Oe <= 1'b1;
				if (dual_q) begin
					lane0Out <= cur[pos_q - 3'h1];
					lane0Oe <= 1'b1;
				end
				if (byteEnd) begin
					pos_q <= 3'h7;
				end else begin
					pos_q <= dual_q ? pos_q - 3'h2 : pos_q - 3'h1;
				end
			end
		end
	end

	// self-timed status write; volatile writes use the short refresh without busy
	always_ff @(posedge clk) begin
		if (!resetn) begin
			run_q <= 1'b0;
			nvBusy_q <= 1'b0;
			timer_q <= '0;
			newSr_q <= sfcmd_pkg::SR_RST;
		end else if (clkEn) begin
			if (wsrGo && !run_q) begin
				run_q <= 1'b1;
				nvBusy_q <= !wsrVol_q;
				timer_q <= wsrVol_q ? sfcmd_pkg::TIMER_W'(sfcmd_pkg::VOL_REFRESH_CYCLES) :
					sfcmd_pkg::TIMER_W'(STATUS_WRITE_CYCLES);
				newSr_q <= sh_q[7:0] & sfcmd_pkg::SR_WR_MASK;
			end else if (timerDone) begin
				run_q <= 1'b0;
				nvBusy_q <= 1'b0;
			end else if (run_q) begin
				timer_q <= timer_q - sfcmd_pkg::TIMER_W'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			sr_q <= sfcmd_pkg::SR_RST;
		end else if (clkEn && timerDone) begin
			sr_q <= newSr_q;
		end
	end

	// write enable latch; a set in the same cycle as a clear wins
	always_ff @(posedge clk) begin
		if (!resetn) begin
			wel_q <= 1'b0;
		end else if (clkEn) begin
			if (cmd1Exec && opc_q == sfcmd_pkg::OPC_WEL_SET) begin
				wel_q <= 1'b1;
			end else if ((cmd1Exec && opc_q == sfcmd_pkg::OPC_WEL_CLR) || (timerDone && nvBusy_q) || arrayOpDone) begin
				wel_q <= 1'b0;
			end
		end
	end

	// volatile arm: consumed by the next status write opcode
	always_ff @(posedge clk) begin
		if (!resetn) begin
			volArm_q <= 1'b0;
			wsrVol_q <= 1'b0;
		end else if (clkEn) begin
			if (cmd1Exec && opc_q == sfcmd_pkg::OPC_VOL_ARM) begin
				volArm_q <= 1'b1;
			end else if (cmd1Exec && opc_q == sfcmd_pkg::OPC_WEL_CLR) begin
				volArm_q <= 1'b0;
			end else if (sclkRise && state_q == sfcmd_pkg::ST_OPC && cnt_q == sfcmd_pkg::CNT_OPC_LAST &&
				opcState == sfcmd_pkg::ST_WRSR) begin
				volArm_q <= 1'b0;
				wsrVol_q <= volArm_q;
			end
		end
	end

	sequence s_vol_start;
		clkEn && wsrGo && !run_q && wsrVol_q;
	endsequence
	sequence s_vol_quiet;
		(!nvBusy_q && run_q) [*5] ##1 (!nvBusy_q && !run_q);
	endsequence

	property p_wel_set;
		@(posedge clk) disable iff (!resetn) clkEn && cmd1Exec && opc_q == sfcmd_pkg::OPC_WEL_SET |=> wel_q;
	endproperty
	a_wel_set: assert property (p_wel_set) else $error("latch not set after set opcode");

	property p_vol_keep;
		@(posedge clk) disable iff (!resetn) clkEn && cmd1Exec && opc_q == sfcmd_pkg::OPC_VOL_ARM |=>
			wel_q == $past(wel_q) && volArm_q;
	endproperty
	a_vol_keep: assert property (p_vol_keep) else $error("volatile enable disturbed latch");

	property p_wel_clr;
		@(posedge clk) disable iff (!resetn) clkEn && cmd1Exec && opc_q == sfcmd_pkg::OPC_WEL_CLR |=>
			!wel_q && !volArm_q;
	endproperty
	a_wel_clr: assert property (p_wel_clr) else $error("latch clear incomplete");

	property p_sr_msb;
		@(posedge clk) disable iff (!resetn) clkEn && sclkFall && state_q == sfcmd_pkg::ST_SROUT && pos_q == 3'h7 |=>
			lane1Out == $past(statusByte[7]) && lane1Oe;
	endproperty
	a_sr_msb: assert property (p_sr_msb) else $error("status msb not driven first");

	property p_lock;
		@(posedge clk) disable iff (!resetn) clkEn && csRise && locked && !run_q |=> !run_q;
	endproperty
	a_lock: assert property (p_lock) else $error("locked status write started");

	property p_vol_refresh;
		@(posedge clk) disable iff (!resetn) s_vol_start |=> s_vol_quiet;
	endproperty
	a_vol_refresh: assert property (p_vol_refresh) else $error("volatile refresh timing or busy wrong");

	property p_nv_busy;
		@(posedge clk) disable iff (!resetn) clkEn && wsrGo && !run_q && !wsrVol_q |=> nvBusy_q && statusByte[0];
	endproperty
	a_nv_busy: assert property (p_nv_busy) else $error("busy not raised for status write");

	property p_ignore_busy;
		@(posedge clk) disable iff (!resetn) clkEn && sclkRise && state_q == sfcmd_pkg::ST_OPC &&
			cnt_q == sfcmd_pkg::CNT_OPC_LAST && busy && opcNext != sfcmd_pkg::OPC_SR_READ |=>
			state_q == sfcmd_pkg::ST_IGN;
	endproperty
	a_ignore_busy: assert property (p_ignore_busy) else $error("command taken while busy");

	property p_cs_float;
		@(posedge clk) disable iff (!resetn) clkEn && !csLow |=> !lane0Oe && !lane1Oe && state_q == sfcmd_pkg::ST_OPC;
	endproperty
	a_cs_float: assert property (p_cs_float) else $error("outputs driven with chip select high");
endmodule
`default_nettype wire

// ===== sfcmd_core_tb.sv
// testbench of the serial flash command decoder: latch, status write and read commands
// assumes sfcmd_host drives the pins; array data is a registered pattern of arrayAddr
`timescale 1ns/1ps
`default_nettype none
module sfcmd_core_tb;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic writeProtectN = 1'b1;
	logic arrayBusy = 1'b0;
	logic arrayOpDone = 1'b0;
	logic [7:0] arrayData = 8'h00;
	logic chipSelectN, serialClk, lane0In, lane0Out, lane0Oe, lane1In, lane1Out, lane1Oe;
	logic [23:0] arrayAddr;
	logic [7:0] statusByte;
	logic [31:0] rx;
	logic rdOe;
	int busyCnt = 0;
	int busyMark = 0;
	int numErrors = 0;
	int numChecks = 0;

	always #5 clk = ~clk;

	function automatic logic [7:0] mem(input logic [23:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h3C;
	endfunction

	always @(posedge clk) arrayData <= mem(arrayAddr);
	always @(posedge clk) if (statusByte[0] === 1'b1) busyCnt <= busyCnt + 1;

	sfcmd_core #(.STATUS_WRITE_TIME_NS(20000)) i_sfcmd_core (.clk(clk), .resetn(resetn), .clkEn(1'b1),
		.chipSelectN(chipSelectN), .serialClk(serialClk), .lane0In(lane0In), .lane0Out(lane0Out),
		.lane0Oe(lane0Oe), .lane1In(lane1In), .lane1Out(lane1Out), .lane1Oe(lane1Oe),
		.writeProtectN(writeProtectN), .arrayBusy(arrayBusy), .arrayOpDone(arrayOpDone),
		.arrayAddr(arrayAddr), .arrayData(arrayData), .statusByte(statusByte));

	sfcmd_host i_sfcmd_host (.clk(clk), .lane0Out(lane0Out), .lane0Oe(lane0Oe), .lane1Out(lane1Out),
		.lane1Oe(lane1Oe), .chipSelectN(chipSelectN), .serialClk(serialClk), .lane0In(lane0In),
		.lane1In(lane1In));

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		numChecks++;
		if (got !== exp) begin
			numErrors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic conclude();
		$display("checks %0d errors %0d", numChecks, numErrors);
		if (numErrors == 0 && numChecks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic cmd(input logic [7:0] op);
		i_sfcmd_host.start();
		i_sfcmd_host.shift(8, 0, {op, 24'h0}, rx);
		i_sfcmd_host.stop();
	endtask

	task automatic wrsr(input logic [7:0] data, input int n);
		i_sfcmd_host.start();
		i_sfcmd_host.shift(8, 0, {sfcmd_pkg::OPC_SR_WRITE, 24'h0}, rx);
		i_sfcmd_host.shift(n, 0, {data, 24'h0}, rx);
		i_sfcmd_host.stop();
	endtask

	// two status bytes in rx[15:0]
	task automatic rdsr();
		i_sfcmd_host.start();
		i_sfcmd_host.shift(8, 0, {sfcmd_pkg::OPC_SR_READ, 24'h0}, rx);
		i_sfcmd_host.shift(16, 0, 32'h0, rx);
		i_sfcmd_host.stop();
	endtask

	// two data bytes in rx[15:0]
	task automatic rd(input logic [7:0] op, input logic [23:0] a, input int dual);
		i_sfcmd_host.start();
		i_sfcmd_host.shift(8, 0, {op, 24'h0}, rx);
		if (op == sfcmd_pkg::OPC_DUAL_IO) begin
			i_sfcmd_host.shift(16, 1, {a, 8'h00}, rx);
		end else begin
			i_sfcmd_host.shift(24, 0, {a, 8'h00}, rx);
		end
		if (op == sfcmd_pkg::OPC_FAST_READ || op == sfcmd_pkg::OPC_DUAL_OUT) begin
			i_sfcmd_host.shift(8, dual ? 2 : 0, 32'hFFFFFFFF, rx);
		end
		i_sfcmd_host.shift(dual ? 8 : 16, dual ? 2 : 0, 32'h0, rx);
		rdOe = lane0Oe | lane1Oe;
		i_sfcmd_host.stop();
		chk("lane enables after frame", 32'h0, {lane0Oe, lane1Oe});
	endtask

	task automatic waitIdle();
		for (int i = 0; i < 3000 && statusByte[0] !== 1'b0; i++) @(posedge clk);
		if (statusByte[0] !== 1'b0) begin
			numErrors++;
			$display("[FAIL] busy end expected 0 seen %b", statusByte[0]);
		end
	endtask

	initial begin
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		chk("status after reset", 8'h00, statusByte);
		cmd(sfcmd_pkg::OPC_WEL_SET);
		chk("latch set", 8'h02, statusByte);
		rdsr();
		chk("status read twice", 32'h0202, rx);
		cmd(sfcmd_pkg::OPC_VOL_ARM);
		chk("volatile arm keeps latch", 8'h02, statusByte);
		cmd(sfcmd_pkg::OPC_WEL_CLR);
		chk("latch clear", 8'h00, statusByte);
		$display("test latch done");

		wrsr(8'hFF, 8);
		chk("write without latch", 8'h00, statusByte);
		cmd(sfcmd_pkg::OPC_VOL_ARM);
		cmd(sfcmd_pkg::OPC_WEL_CLR);
		wrsr(8'hFF, 8);
		chk("write after arm cancelled", 8'h00, statusByte);
		cmd(sfcmd_pkg::OPC_WEL_SET);
		wrsr(8'hFF, 7);
		chk("partial byte write", 8'h02, statusByte);
		$display("test refusals done");

		wrsr(8'hFF, 8);
		chk("busy after write", 8'h03, statusByte);
		rdsr();
		chk("status read while busy", 32'h0303, rx);
		rd(sfcmd_pkg::OPC_READ, 24'h000010, 0);
		chk("read output while busy", 32'h0, rdOe);
		cmd(sfcmd_pkg::OPC_WEL_CLR);
		chk("clear ignored while busy", 8'h03, statusByte);
		waitIdle();
		chk("status after write cycle", 8'hBC, statusByte);
		$display("test status write done");

		@(posedge clk);
		writeProtectN <= 1'b0;
		cmd(sfcmd_pkg::OPC_WEL_SET);
		wrsr(8'h00, 8);
		chk("locked write", 32'h2F, statusByte[7:2]);
		@(posedge clk);
		writeProtectN <= 1'b1;
		cmd(sfcmd_pkg::OPC_WEL_CLR);
		cmd(sfcmd_pkg::OPC_VOL_ARM);
		busyMark = busyCnt;
		wrsr(8'h24, 8);
		chk("volatile write", 8'h24, statusByte);
		chk("busy during refresh", 32'h0, busyCnt - busyMark);
		$display("test lock done");

		rd(sfcmd_pkg::OPC_READ, 24'h0000FF, 0);
		chk("read", {mem(24'h0000FF), mem(24'h000100)}, rx[15:0]);
		rd(sfcmd_pkg::OPC_FAST_READ, 24'h123456, 0);
		chk("fast read", {mem(24'h123456), mem(24'h123457)}, rx[15:0]);
		rd(sfcmd_pkg::OPC_DUAL_OUT, 24'hABCDEF, 1);
		chk("dual output read", {mem(24'hABCDEF), mem(24'hABCDF0)}, rx[15:0]);
		rd(sfcmd_pkg::OPC_DUAL_IO, 24'h5A12FF, 1);
		chk("dual io read", {mem(24'h5A12FF), mem(24'h5A1300)}, rx[15:0]);
		$display("test reads done");

		cmd(sfcmd_pkg::OPC_WEL_SET);
		@(posedge clk);
		arrayBusy <= 1'b1;
		repeat (2) @(posedge clk);
		chk("array busy in status", 8'h27, statusByte);
		cmd(sfcmd_pkg::OPC_WEL_CLR);
		rd(sfcmd_pkg::OPC_READ, 24'h000000, 0);
		chk("read output while array busy", 32'h0, rdOe);
		chk("clear ignored while array busy", 8'h27, statusByte);
		@(posedge clk);
		arrayOpDone <= 1'b1;
		@(posedge clk);
		arrayOpDone <= 1'b0;
		arrayBusy <= 1'b0;
		repeat (2) @(posedge clk);
		chk("latch after array done", 8'h24, statusByte);
		$display("test array busy done");
		conclude();
	end
endmodule
`default_nettype wire

// ===== sfcmd_host.sv
// host side model: drives chip select, serial clock and both data lanes in spi mode 0
// assumes device outputs registered on clk; lane levels resolved here from every party's enable
`timescale 1ns/1ps
`default_nettype none
module sfcmd_host (
	input wire logic clk,
	input wire logic lane0Out,
	input wire logic lane0Oe,
	input wire logic lane1Out,
	input wire logic lane1Oe,
	output logic chipSelectN,
	output logic serialClk,
	output logic lane0In,
	output logic lane1In
);
	logic hostOe0 = 1'b0;
	logic hostOe1 = 1'b0;
	logic hostD0 = 1'b0;
	logic hostD1 = 1'b0;
	logic toggle = 1'b0;
	logic csN = 1'b1;
	logic sclk = 1'b0;
	assign chipSelectN = csN;
	assign serialClk = sclk;
	// released lines change every cycle so a stale value never passes
	always @(posedge clk) toggle <= ~toggle;
	assign lane0In = lane0Oe ? lane0Out : (hostOe0 ? hostD0 : toggle);
	assign lane1In = lane1Oe ? lane1Out : (hostOe1 ? hostD1 : ~toggle);

	task automatic start();
		@(posedge clk);
		csN <= 1'b0;
		repeat (4) @(posedge clk);
	endtask

	// chip select rises one cycle after the last falling clock, always on a whole count of clocks
	task automatic stop();
		@(posedge clk);
		csN <= 1'b1;
		hostOe0 <= 1'b0;
		hostOe1 <= 1'b0;
		repeat (12) @(posedge clk);
	endtask

	// mode 0 single lane, 1 dual input, 2 dual output with both lanes released
	task automatic shift(input int n, input int mode, input logic [31:0] tx, output logic [31:0] rx);
		logic [31:0] sr;
		sr = tx;
		rx = 32'h0;
		for (int i = 0; i < n; i++) begin
			hostOe0 <= (mode != 2);
			hostOe1 <= (mode == 1);
			hostD1 <= sr[31];
			hostD0 <= (mode == 1) ? sr[30] : sr[31];
			sr = (mode == 1) ? (sr << 2) : (sr << 1);
			repeat (4) @(posedge clk);
			sclk <= 1'b1;
			repeat (3) @(posedge clk);
			@(negedge clk);
			rx = (mode == 0) ? {rx[30:0], lane1In} : {rx[29:0], lane1In, lane0In};
			@(posedge clk);
			sclk <= 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// ===== sfcmd_pkg.sv
// constants, opcodes, status layout and states of the serial flash command decoder
// assumes a 100 MHz system clock; shared by the decoder and its pin synchroniser
package sfcmd_pkg;

	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned VOLATILE_REFRESH_TIME_NS = 50;
	localparam int unsigned VOL_REFRESH_CYCLES = VOLATILE_REFRESH_TIME_NS / CLK_PERIOD_NS;
	localparam int unsigned TIMER_W = 24;

	// pin vector layout
	localparam int unsigned PIN_W = 5;
	localparam int unsigned PIN_CS = 0;
	localparam int unsigned PIN_SCLK = 1;
	localparam int unsigned PIN_LANE0 = 2;
	localparam int unsigned PIN_LANE1 = 3;
	localparam int unsigned PIN_WP = 4;
	localparam logic [4:0] PIN_RST = 5'h11;

	// opcodes
	localparam logic [7:0] OPC_WEL_SET = 8'h06;
	localparam logic [7:0] OPC_VOL_ARM = 8'h50;
	localparam logic [7:0] OPC_WEL_CLR = 8'h04;
	localparam logic [7:0] OPC_SR_READ = 8'h05;
	localparam logic [7:0] OPC_SR_WRITE = 8'h01;
	localparam logic [7:0] OPC_READ = 8'h03;
	localparam logic [7:0] OPC_FAST_READ = 8'h0B;
	localparam logic [7:0] OPC_DUAL_OUT = 8'h3B;
	localparam logic [7:0] OPC_DUAL_IO = 8'hBB;

	// status layout
	localparam int unsigned SR_BUSY = 0;
	localparam int unsigned SR_WEL = 1;
	localparam int unsigned SR_LOCK = 7;
	localparam logic [7:0] SR_WR_MASK = 8'hBC;
	localparam logic [7:0] SR_RST = 8'h00;

	// clock counts per phase
	localparam logic [4:0] CNT_OPC_LAST = 5'h07;
	localparam logic [4:0] CNT_ADDR_LAST = 5'h17;
	localparam logic [4:0] CNT_DADDR_LAST = 5'h0F;
	localparam logic [4:0] CNT_DUMMY_LAST = 5'h07;
	localparam logic [4:0] CNT_WRSR_BYTE = 5'h08;
	localparam logic [4:0] CNT_MAX = 5'h1F;

	typedef enum logic [2:0] {
		ST_OPC = 3'h0,
		ST_CMD1 = 3'h1,
		ST_ADDR = 3'h2,
		ST_DUMMY = 3'h3,
		ST_SROUT = 3'h4,
		ST_RDOUT = 3'h5,
		ST_WRSR = 3'h6,
		ST_IGN = 3'h7
	} sfcmd_state_e;

endpackage

// ===== sfcmd_sync.sv
// three-stage pin synchroniser with agreement filter and edge pulses
// assumes pins asynchronous to clk; an edge counts once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module sfcmd_sync (
	input wire logic clk,
	input wire logic resetn,
	input wire logic clkEn,
	input wire logic [sfcmd_pkg::PIN_W-1:0] pinIn,
	output logic [sfcmd_pkg::PIN_W-1:0] pinLvl,
	output logic [sfcmd_pkg::PIN_W-1:0] pinRise,
	output logic [sfcmd_pkg::PIN_W-1:0] pinFall
);
	logic [sfcmd_pkg::PIN_W-1:0] s1_q;
	logic [sfcmd_pkg::PIN_W-1:0] s2_q;
	logic [sfcmd_pkg::PIN_W-1:0] s3_q;
	logic [sfcmd_pkg::PIN_W-1:0] lvl_q;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			s1_q <= sfcmd_pkg::PIN_RST;
			s2_q <= sfcmd_pkg::PIN_RST;
			s3_q <= sfcmd_pkg::PIN_RST;
			lvl_q <= sfcmd_pkg::PIN_RST;
		end else if (clkEn) begin
			s1_q <= pinIn;
			s2_q <= s1_q;
			s3_q <= s2_q;
			lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q ^ s3_q));
		end
	end

	assign pinLvl = lvl_q;
	assign pinRise = {sfcmd_pkg::PIN_W{clkEn}} & s2_q & s3_q & ~lvl_q;
	assign pinFall = {sfcmd_pkg::PIN_W{clkEn}} & ~s2_q & ~s3_q & lvl_q;
endmodule
`default_nettype wire
